/* hw/hbc_addr_decode.sv */
// combinational local-device decode plus optional address latch
module hbc_addr_decode
   import hbc_pkg::*;
(
   input  wire logic                         sysClk,
   input  wire logic                         srst,
   input  wire logic [hbc_pkg::HBC_ADDR_W-1:0] addrIn,
   input  wire logic                         addressQualifierN,
   input  wire logic                         addressLatchStrobeN,
   input  wire logic                         latchEnable,
   input  wire logic [hbc_pkg::HBC_DEC_W-1:0] baseHigh,
   output logic                              localDeviceSelN,
   output logic [hbc_pkg::HBC_LATCH_W-1:0]   latchedAddr
);
   import hbc_pkg::*;

   logic                      strobeDly_q, strobeDly_d;
   logic [HBC_LATCH_W-1:0]    addr_q, addr_d;
   logic                      qual_q, qual_d;
   logic [HBC_DEC_W-1:0]      decAddr;
   logic                      decQual;

   ////////////////////////////////////////////////////////////////////////////
   // capture on the strobe's rising edge
   always_comb begin
      strobeDly_d = addressLatchStrobeN;
      addr_d      = addr_q;
      qual_d      = qual_q;
      if (addressLatchStrobeN && !strobeDly_q) begin // [R15]
         addr_d = addrIn[HBC_DEC_MSB:HBC_LATCH_LSB];
         qual_d = addressQualifierN;
      end
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         strobeDly_q <= 1'b1;
         addr_q      <= '0;
         qual_q      <= 1'b1;
      end else begin
         strobeDly_q <= strobeDly_d;
         addr_q      <= addr_d;
         qual_q      <= qual_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode stays flop-free in the transparent case; latched values feed it otherwise
   always_comb begin
      decAddr = latchEnable ? addr_q[HBC_LATCH_W-1 -: HBC_DEC_W] : addrIn[HBC_DEC_MSB:HBC_DEC_LSB];
      decQual = latchEnable ? qual_q : addressQualifierN;
      localDeviceSelN = !(!decQual && (decAddr == baseHigh)); // [R6] [R7] [R17]
   end

   assign latchedAddr = addr_q;

endmodule // hbc_addr_decode

/* hw/hbc_host_ctrl.sv */
// How it works
// R1: sync ready extends EISA and VL accesses
// R2: VL mode: sync ready falls for ready
// R3: sync ready changes only on clock
// R4: burst mode: sync ready low during waits
// R5: irq output low when status set
// R6: select low on qualifier low, match
// R7: select decode is purely combinational
// R8: host drives read strobe low to read
// R9: async ready stretches asynchronous bus cycles
// R10: host drives cycle after address phase
// R11: burst: cycle high read, low write
// R12: strap low or floating: synchronous mode
// R13: strap high: async 8/16 or burst
// R14: host drives write/read high on writes
// R15: latch address on address strobe rise
// R16: host drives write strobe low to write
// R17: select high otherwise
// R18: irq released high when status clears
module hbc_host_ctrl
   import hbc_pkg::*;
#(
   parameter int unsigned IRQ_BITS = 16
)(
   input  wire logic                            sysClk,
   input  wire logic                            srst,
   input  wire logic                            bus_mode_strap,
   input  wire logic                            burstStrap,
   input  wire logic                            width16Strap,
   input  wire logic [hbc_pkg::HBC_ADDR_W-1:0]  addrIn,
   input  wire logic                            address_qualifier_n,
   input  wire logic                            address_latch_strobe_n,
   input  wire logic                            latchEnable,
   input  wire logic [hbc_pkg::HBC_DEC_W-1:0]   baseHigh,
   input  wire logic                            read_strobe_n,
   input  wire logic                            write_strobe_n,
   input  wire logic                            cycle_phase_n,
   input  wire logic                            sync_write_read,
   input  wire logic [hbc_pkg::HBC_WAIT_W-1:0]  waitCount,
   input  wire logic [IRQ_BITS-1:0]             irqStatus,
   output logic                                 sync_ready_n,
   output logic                                 async_ready,
   output logic                                 asyncReadyOen,
   output logic                                 irq_out_n,
   output logic                                 irqOutOen,
   output logic                                 local_device_sel_n,
   output logic [hbc_pkg::HBC_LATCH_W-1:0]      latchedAddr,
   output hbc_pkg::hbc_mode_e                   busMode,
   output logic                                 accessWrite,
   output logic                                 accessStrobe
);
   import hbc_pkg::*;

   // elaboration-time guard: an empty status vector leaves nothing to flag
   if (IRQ_BITS < 1) begin : g_bad_irq_bits
      $error("IRQ_BITS must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode captured one clock after reset releases, never under reset itself
   hbc_mode_e mode_q, mode_d;
   logic      strapDone_q, strapDone_d;

   always_comb begin
      mode_d      = mode_q;
      strapDone_d = 1'b1;
      if (!strapDone_q) begin
         if (!bus_mode_strap) begin
            mode_d = HBC_MODE_SYNC;                        // [R12]
         end else if (burstStrap) begin
            mode_d = HBC_MODE_BURST32;                     // [R13]
         end else if (width16Strap) begin
            mode_d = HBC_MODE_ASYNC16;                     // [R13]
         end else begin
            mode_d = HBC_MODE_ASYNC8;                      // [R13]
         end
      end
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         mode_q      <= HBC_MODE_SYNC;
         strapDone_q <= 1'b0;
      end else begin
         mode_q      <= mode_d;
         strapDone_q <= strapDone_d;
      end
   end

   assign busMode = mode_q;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic selN;

   hbc_addr_decode u_dec (
      .sysClk              (sysClk),
      .srst                (srst),
      .addrIn              (addrIn),
      .addressQualifierN   (address_qualifier_n),
      .addressLatchStrobeN (address_latch_strobe_n),
      .latchEnable         (latchEnable),
      .baseHigh            (baseHigh),
      .localDeviceSelN     (selN),
      .latchedAddr         (latchedAddr)
   );

   assign local_device_sel_n = selN;                      // [R7]

   ////////////////////////////////////////////////////////////////////////////
   // access detection per mode; strobes only matter when selected
   logic isSync;
   logic isBurst;
   logic isAsync;
   logic syncReq;
   logic burstReq;
   logic asyncReq;
   logic reqActive;
   logic reqDly_q, reqDly_d;

   always_comb begin
      isSync   = (mode_q == HBC_MODE_SYNC);
      isBurst  = (mode_q == HBC_MODE_BURST32);
      isAsync  = !isSync && !isBurst;
      // host marks command phase by lowering cycle after address [R10]
      syncReq  = isSync && !cycle_phase_n && !selN;
      // burst: cycle level carries direction, so a strobe marks the access [R11]
      burstReq = isBurst && !selN && (!read_strobe_n || !write_strobe_n);
      // host strobes are active low [R8] [R16]
      asyncReq = isAsync && !selN && (!read_strobe_n || !write_strobe_n);
      reqActive = syncReq || burstReq || asyncReq;
      reqDly_d  = reqActive;
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         reqDly_q <= 1'b0;
      end else begin
         reqDly_q <= reqDly_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wait-state generator shared by all modes
   logic waiting;
   logic doneEdge;

   hbc_ready_gen u_rdy (
      .sysClk      (sysClk),
      .srst        (srst),
      .accessStart (reqActive && !reqDly_q),
      .accessEnd   (!reqActive && reqDly_q),
      .waitCount   (waitCount),
      .waiting     (waiting),
      .doneEdge    (doneEdge)
   );

   ////////////////////////////////////////////////////////////////////////////
   // direction: sync uses write/read pin, burst uses cycle level, async strobes
   logic write_q, write_d;

   always_comb begin
      write_d = write_q;
      if (reqActive && !reqDly_q) begin
         if (isSync) begin
            write_d = sync_write_read;                     // [R14]
         end else if (isBurst) begin
            write_d = !cycle_phase_n;                      // [R11]
         end else begin
            write_d = !write_strobe_n;
         end
      end
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         write_q <= 1'b0;
      end else begin
         write_q <= write_d;
      end
   end

   assign accessWrite  = write_q;
   assign accessStrobe = doneEdge && !reqDly_q ? 1'b0 : (doneEdge && reqActive);

   ////////////////////////////////////////////////////////////////////////////
   // ready outputs, all registered so they move only on the clock
   logic sync_ready_n_q, sync_ready_n_d;
   logic async_ready_q, async_ready_d;
   logic ardyOen_q, ardyOen_d;

   always_comb begin
      sync_ready_n_d   = 1'b1;
      async_ready_d    = 1'b1;
      ardyOen_d = 1'b1;
      case (mode_q)
         HBC_MODE_SYNC: begin
            // high while waiting; falling edge marks ready [R1] [R2]
            sync_ready_n_d = !(reqActive && doneEdge);
         end
         HBC_MODE_BURST32: begin
            // low only while wait states are inserted [R1] [R4]
            sync_ready_n_d = !(reqActive && waiting);
         end
         HBC_MODE_ASYNC8, HBC_MODE_ASYNC16: begin
            // open drain: pull low to stretch, release otherwise [R9]
            async_ready_d    = 1'b0;
            ardyOen_d = !(asyncReq && !doneEdge);
         end
         default: begin
            sync_ready_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         sync_ready_n_q   <= 1'b1;
         async_ready_q    <= 1'b1;
         ardyOen_q <= 1'b1;
      end else begin
         sync_ready_n_q   <= sync_ready_n_d;                             // [R3]
         async_ready_q    <= async_ready_d;
         ardyOen_q <= ardyOen_d;
      end
   end

   assign sync_ready_n  = sync_ready_n_q;
   assign async_ready   = async_ready_q;
   assign asyncReadyOen = ardyOen_q;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: open drain, pull-up holds the idle level
   logic irqOen_q, irqOen_d;

   always_comb begin
      irqOen_d = !(|irqStatus);                            // [R5] [R18]
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         irqOen_q <= 1'b1;
      end else begin
         irqOen_q <= irqOen_d;
      end
   end

   assign irq_out_n = 1'b0;
   assign irqOutOen = irqOen_q;

endmodule // hbc_host_ctrl

/* hw/hbc_ready_gen.sv */
// wait-state counter driving both ready outputs
module hbc_ready_gen
   import hbc_pkg::*;
(
   input  wire logic                          sysClk,
   input  wire logic                          srst,
   input  wire logic                          accessStart,
   input  wire logic                          accessEnd,
   input  wire logic [hbc_pkg::HBC_WAIT_W-1:0] waitCount,
   output logic                               waiting,
   output logic                               doneEdge
);
   import hbc_pkg::*;

   logic [HBC_WAIT_W-1:0] cnt_q, cnt_d;
   logic                  busy_q, busy_d;
   logic                  done_q, done_d;

   ////////////////////////////////////////////////////////////////////////////
   // count waits down; done holds until the access ends
   always_comb begin
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = done_q;
      if (accessEnd) begin
         busy_d = 1'b0;
         done_d = 1'b0;
      end else if (accessStart && !busy_q) begin
         busy_d = 1'b1;
         done_d = (waitCount == HBC_WAIT_ZERO);
         cnt_d  = waitCount;
      end else if (busy_q && !done_q) begin
         if (cnt_q <= HBC_WAIT_ONE) begin
            done_d = 1'b1;
            cnt_d  = HBC_WAIT_ZERO;
         end else begin
            cnt_d = cnt_q - HBC_WAIT_ONE;
         end
      end
   end

   always_ff @(posedge sysClk) begin
      if (srst) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign waiting  = busy_q && !done_q;
   assign doneEdge = busy_q && done_q;

endmodule // hbc_ready_gen

/* inc/hbc_pkg.sv */
package hbc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus modes chosen by the strap and the width straps
   typedef enum logic [1:0] {
      HBC_MODE_SYNC,
      HBC_MODE_ASYNC8,
      HBC_MODE_ASYNC16,
      HBC_MODE_BURST32
   } hbc_mode_e;

   ////////////////////////////////////////////////////////////////////////////
   // address decode geometry
   localparam int unsigned HBC_ADDR_W     = 16;
   localparam int unsigned HBC_DEC_LSB    = 4;
   localparam int unsigned HBC_DEC_MSB    = 15;
   localparam int unsigned HBC_DEC_W      = HBC_DEC_MSB - HBC_DEC_LSB + 1;
   localparam int unsigned HBC_LATCH_LSB  = 1;
   localparam int unsigned HBC_LATCH_W    = HBC_DEC_MSB - HBC_LATCH_LSB + 1;
   localparam logic [HBC_DEC_W-1:0] HBC_BASE_RST = 12'h0300;

   ////////////////////////////////////////////////////////////////////////////
   // wait state count width
   localparam int unsigned HBC_WAIT_W     = 4;
   localparam logic [HBC_WAIT_W-1:0] HBC_WAIT_DEF = 4'h0002;
   localparam logic [HBC_WAIT_W-1:0] HBC_WAIT_ONE = 4'h0001;
   localparam logic [HBC_WAIT_W-1:0] HBC_WAIT_ZERO = 4'h0000;

endpackage

/* tb/hbc_host_ctrl_properties.sv */
module hbc_host_ctrl_properties
   import hbc_pkg::*;
#(
   parameter int unsigned IRQ_BITS = 16
)(
   input wire logic                           sysClk,
   input wire logic                           srst,
   input wire logic                           bus_mode_strap,
   input wire logic                           burstStrap,
   input wire logic                           width16Strap,
   input wire logic [hbc_pkg::HBC_ADDR_W-1:0] addrIn,
   input wire logic                           address_qualifier_n,
   input wire logic                           latchEnable,
   input wire logic [hbc_pkg::HBC_DEC_W-1:0]  baseHigh,
   input wire logic                           read_strobe_n,
   input wire logic                           write_strobe_n,
   input wire logic                           cycle_phase_n,
   input wire logic [hbc_pkg::HBC_WAIT_W-1:0] waitCount,
   input wire logic [IRQ_BITS-1:0]            irqStatus,
   input wire logic                           sync_ready_n,
   input wire logic                           async_ready,
   input wire logic                           asyncReadyOen,
   input wire logic                           irq_out_n,
   input wire logic                           irqOutOen,
   input wire logic                           local_device_sel_n,
   input wire logic                           accessStrobe,
   input wire hbc_pkg::hbc_mode_e             busMode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sysClk); endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////////
   // requests as the device sees them: selected plus command or strobe
   wire logic hit  = (addrIn[HBC_DEC_MSB:HBC_DEC_LSB] == baseHigh);
   wire logic sReq = !local_device_sel_n && !cycle_phase_n;
   wire logic aReq = !local_device_sel_n && !(read_strobe_n && write_strobe_n);

   ////////////////////////////////////////////////////////////////////////////
   // decode is checked in the same cycle: any register in the path fails it
   property p_sel_match;
      !latchEnable && !address_qualifier_n && hit |-> !local_device_sel_n;
   endproperty
   a_sel_match: assert property (p_sel_match) else $error("select not low");
   property p_sel_idle;
      !latchEnable && (address_qualifier_n || !hit) |-> local_device_sel_n;
   endproperty
   a_sel_idle: assert property (p_sel_idle) else $error("select not high");
   property p_irq_set;
      irqStatus != '0 |=> !irqOutOen && !irq_out_n;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq not driven");
   property p_irq_clr;
      irqStatus == '0 |=> irqOutOen;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq not released");
   property p_sync_wait;
      busMode == HBC_MODE_SYNC && waitCount == 4'h2 && $rose(sReq)
         |-> sync_ready_n [*4] ##1 !sync_ready_n;
   endproperty
   a_sync_wait: assert property (p_sync_wait) else $error("sync ready late");
   property p_sync_rel;
      busMode == HBC_MODE_SYNC && !sync_ready_n && !sReq |=> sync_ready_n;
   endproperty
   a_sync_rel: assert property (p_sync_rel) else $error("sync ready stuck");
   property p_sync_strobe;
      busMode == HBC_MODE_SYNC && !sync_ready_n && sReq |-> accessStrobe;
   endproperty
   a_sync_strobe: assert property (p_sync_strobe) else $error("strobe missing");
   property p_burst_wait;
      busMode == HBC_MODE_BURST32 && waitCount == 4'h4 && $rose(aReq)
         |-> ##[1:4] !sync_ready_n;
   endproperty
   a_burst_wait: assert property (p_burst_wait) else $error("no burst wait");
   property p_async_wait;
      busMode inside {HBC_MODE_ASYNC8, HBC_MODE_ASYNC16} && waitCount == 4'h4
         && $rose(aReq) |-> ##[1:4] !asyncReadyOen;
   endproperty
   a_async_wait: assert property (p_async_wait) else $error("no async stretch");
   property p_async_low;
      busMode inside {HBC_MODE_ASYNC8, HBC_MODE_ASYNC16} && !asyncReadyOen |-> !async_ready;
   endproperty
   a_async_low: assert property (p_async_low) else $error("async ready not low");
   property p_mode;
      $fell(srst) |=> busMode == (!$past(bus_mode_strap) ? HBC_MODE_SYNC :
         $past(burstStrap) ? HBC_MODE_BURST32 :
         $past(width16Strap) ? HBC_MODE_ASYNC16 : HBC_MODE_ASYNC8);
   endproperty
   a_mode: assert property (p_mode) else $error("bus mode wrong");
endmodule // hbc_host_ctrl_properties

bind hbc_host_ctrl hbc_host_ctrl_properties #(.IRQ_BITS(IRQ_BITS)) i_hbc_host_ctrl_properties (.*);

/* tb/hbc_host_ctrl_test.sv */
module hbc_host_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import hbc_pkg::*;

`define CHK(act, exp) begin testsRun++; if ((act) !== (exp)) begin nMismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end

   logic                   sysClk, srst, bus_mode_strap, burstStrap, width16Strap, go, wr;
   logic                   address_qualifier_n, address_latch_strobe_n, latchEnable, busy;
   logic                   read_strobe_n, write_strobe_n, cycle_phase_n, sync_write_read;
   logic                   sync_ready_n, async_ready, asyncReadyOen, irq_out_n, irqOutOen;
   logic                   local_device_sel_n, accessWrite, accessStrobe;
   logic [HBC_ADDR_W-1:0]  addrIn;
   logic [HBC_DEC_W-1:0]   baseHigh;
   logic [HBC_WAIT_W-1:0]  waitCount;
   logic [HBC_LATCH_W-1:0] latchedAddr;
   logic [15:0]            irqStatus, rnd;
   logic [3:0]             hold;
   logic [2:0]             q[$], e;
   hbc_mode_e              busMode, mode;
   int                     nMismatch = 0, testsRun = 0;

   hbc_host_ctrl #(.IRQ_BITS(16)) i_hbc_host_ctrl (.*);
   hbc_host_model i_hbc_host_model (.*);

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge sysClk);
   endtask

   task automatic conclude;
      if (nMismatch == 0 && testsRun > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial sysClk = 1'b0;
   always #4 sysClk = ~sysClk;

   ////////////////////////////////////////////////////////////////////////////
   // transfer outcome judged once the host lets go of the bus
   always @(negedge busy) begin
      if (q.size() > 0) begin
         #1;
         e = q.pop_front();
         `CHK({accessWrite, busMode}, e)
      end
   end

   // generous span: the whole run is a few hundred cycles
   initial begin
      tick(3000);
      nMismatch++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////
   // every bus mode in turn, straps held across its own reset
   initial begin
      {srst, go, wr, latchEnable, address_latch_strobe_n, address_qualifier_n} = 6'h23;
      {bus_mode_strap, burstStrap, width16Strap} = 3'h0;
      {addrIn, baseHigh, waitCount, hold, irqStatus} = '0;
      rnd = 16'h002f;
      mode = HBC_MODE_SYNC;
      for (int m = 0; m < 4; m++) begin
         srst           <= 1'b1;
         bus_mode_strap <= (m != 0);
         burstStrap     <= (m == 3);
         width16Strap   <= (m == 2);
         mode           <= hbc_mode_e'(m);
         tick(4);
         srst <= 1'b0;
         tick(2);
         rnd = lfsr(rnd);
         baseHigh            <= rnd[11:0];
         addrIn              <= {rnd[11:0], rnd[15:12]};
         address_qualifier_n <= 1'b0;
         irqStatus           <= rnd | 16'h0001;
         tick(2);
         #1;
         `CHK(local_device_sel_n, 1'b0)
         `CHK({irqOutOen, irq_out_n}, 2'h0)
         tick(1);
         addrIn[4] <= ~addrIn[4];
         irqStatus <= '0;
         tick(2);
         #1;
         `CHK(local_device_sel_n, 1'b1)
         `CHK(irqOutOen, 1'b1)
         // latched decode must ignore the live address once captured
         tick(1);
         addrIn                 <= {baseHigh, 4'h6};
         address_latch_strobe_n <= 1'b0;
         tick(1);
         address_latch_strobe_n <= 1'b1;
         tick(2);
         addrIn      <= ~addrIn;
         latchEnable <= 1'b1;
         tick(2);
         #1;
         `CHK(latchedAddr, {baseHigh, 3'h3})
         `CHK(local_device_sel_n, 1'b0)
         tick(1);
         latchEnable <= 1'b0;
         addrIn      <= {baseHigh, rnd[3:0]};
         tick(2);
         for (int t = 0; t < 4; t++) begin
            wr        <= t[0];
            waitCount <= (t < 2) ? 4'h2 : 4'h4;
            hold      <= (t < 2) ? 4'h5 : 4'h7;
            go        <= 1'b1;
            q.push_back({t[0], 2'(m)});
            tick(1);
            go <= 1'b0;
            @(negedge busy);
            tick(3);
         end
      end
      tick(2);
      conclude();
   end
endmodule // hbc_host_ctrl_test

/* tb/hbc_host_model.sv */
module hbc_host_model
   import hbc_pkg::*;
(
   input  wire logic               sysClk,
   input  wire logic               go,
   input  wire logic               wr,
   input  wire hbc_pkg::hbc_mode_e mode,
   input  wire logic [3:0]         hold,
   input  wire logic               sync_ready_n,
   output logic                    read_strobe_n,
   output logic                    write_strobe_n,
   output logic                    cycle_phase_n,
   output logic                    sync_write_read,
   output logic                    busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;

   initial begin
      {read_strobe_n, write_strobe_n, cycle_phase_n, busy} = 4'he;
      sync_write_read = 1'b0;
      cnt = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one access at a time; sync mode waits for ready, others hold a set span
   always @(posedge sysClk) begin
      if (!busy) begin
         sync_write_read <= ~sync_write_read; // not meaningful in idle: keep it moving
         if (go) begin
            busy            <= 1'b1;
            cnt             <= hold;
            sync_write_read <= wr;
            cycle_phase_n   <= (mode == HBC_MODE_BURST32) ? !wr : (mode != HBC_MODE_SYNC);
            read_strobe_n   <= wr || mode == HBC_MODE_SYNC;
            write_strobe_n  <= !wr || mode == HBC_MODE_SYNC;
         end
      end else if (mode == HBC_MODE_SYNC ? !sync_ready_n : cnt == 4'h0) begin
         {read_strobe_n, write_strobe_n, cycle_phase_n, busy} <= 4'he;
      end else begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule // hbc_host_model
